// ==== core/nvsram_host_pkg.sv ====
// constants and types for the nonvolatile sram host sequencer
// assumes a 100 MHz clock and an asynchronous 32k x 8 shadowed sram
package nvsram_host_pkg;

  localparam int CLOCK_PERIOD_NS            = 10;
  localparam int STORE_DURATION_MS          = 10;
  localparam int RECALL_DURATION_US         = 20;
  localparam int POWERUP_RECALL_DURATION_US = 550;

  // waits are upper bounds on the device, so round up
  localparam int STORE_CYCLES   =
    (STORE_DURATION_MS * 1000000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int RECALL_CYCLES  =
    (RECALL_DURATION_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int POWERUP_CYCLES =
    (POWERUP_RECALL_DURATION_US * 1000 + CLOCK_PERIOD_NS - 1)
    / CLOCK_PERIOD_NS;

  localparam int ADDR_W  = 15;
  localparam int DATA_W  = 8;
  localparam int WAIT_W  = 21;
  localparam int SEQ_LEN = 6;

  localparam logic [1:0]  SETUP_LAST = 2'h1;
  localparam logic [3:0]  PULSE_LAST = 4'h9;
  localparam logic [2:0]  SEQ_LAST   = 3'h5;

  localparam logic [13:0] SEQ_ADDR0       = 14'h0e38;
  localparam logic [13:0] SEQ_ADDR1       = 14'h31c7;
  localparam logic [13:0] SEQ_ADDR2       = 14'h03e0;
  localparam logic [13:0] SEQ_ADDR3       = 14'h3c1f;
  localparam logic [13:0] SEQ_ADDR4       = 14'h303f;
  localparam logic [13:0] SEQ_STORE_LAST  = 14'h0fc0;
  localparam logic [13:0] SEQ_RECALL_LAST = 14'h0c63;

  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

  typedef enum logic [1:0] {
    op_read,
    op_write,
    op_store,
    op_recall
  } op_e;

endpackage

// ==== core/pin_sync.sv ====
// three-flop input synchroniser with agreement filter
// assumes inputs asynchronous to clock; output is registered
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] value
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a change counts once the second and third stages agree
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      value <= '0;
    end else if (stage2 == stage3) begin
      value <= stage3;
    end
  end

endmodule

// ==== core/nvsram_host.sv ====
// host sequencer driving a shadowed sram through its pins
// assumes the supply flag reports supply above the switch threshold
`timescale 1ns/100ps
module nvsram_host #(
  parameter int STORE_WAIT   = nvsram_host_pkg::STORE_CYCLES,
  parameter int POWERUP_WAIT = nvsram_host_pkg::POWERUP_CYCLES
) (
  input  wire logic                                clock,
  input  wire logic                                rst,
  input  wire logic                                cmd_valid,
  output logic                                     cmd_ready,
  input  wire nvsram_host_pkg::op_e                cmd_op,
  input  wire logic [nvsram_host_pkg::ADDR_W-1:0]  cmd_addr,
  input  wire logic [nvsram_host_pkg::DATA_W-1:0]  cmd_wdata,
  output logic                                     rsp_valid,
  output logic [nvsram_host_pkg::DATA_W-1:0]       rsp_rdata,
  output logic                                     busy,
  input  wire logic                                supply_above_switch,
  output logic [nvsram_host_pkg::ADDR_W-1:0]       address_lines,
  output logic                                     chip_sel_n,
  output logic                                     out_en_n,
  output logic                                     write_en_n,
  input  wire logic [nvsram_host_pkg::DATA_W-1:0]  data_lines_in,
  output logic [nvsram_host_pkg::DATA_W-1:0]       data_lines_out,
  output logic                                     data_lines_oe
);

  typedef enum logic [2:0] {
    st_power,
    st_idle,
    st_setup,
    st_pulse,
    st_hold,
    st_wait
  } state_e;

  state_e                               state;
  nvsram_host_pkg::op_e                 op;
  logic [nvsram_host_pkg::ADDR_W-1:0]   addr;
  logic [nvsram_host_pkg::WAIT_W-1:0]   count;
  logic [2:0]                           seq_idx;
  logic [13:0]                          seq_pick;
  logic                                 seq_active;
  logic                                 supply_ok;
  logic [nvsram_host_pkg::DATA_W-1:0]   data_sync;
  logic                                 strobe_next;
  logic                                 accept;

  pin_sync #(.WIDTH(1)) u_supply_sync (
    .clock (clock),
    .rst   (rst),
    .pin   (supply_above_switch),
    .value (supply_ok)
  );

  pin_sync #(.WIDTH(nvsram_host_pkg::DATA_W)) u_data_sync (
    .clock (clock),
    .rst   (rst),
    .pin   (data_lines_in),
    .value (data_sync)
  );

  assign cmd_ready  = (state == st_idle);
  assign busy       = (state != st_idle);
  assign accept     = cmd_valid && cmd_ready;
  assign seq_active = (op == nvsram_host_pkg::op_store) ||
                      (op == nvsram_host_pkg::op_recall);

  // sequence address for the current step, upper bit left low
  always_comb begin
    unique case (seq_idx)
      3'h0:    seq_pick = nvsram_host_pkg::SEQ_ADDR0;
      3'h1:    seq_pick = nvsram_host_pkg::SEQ_ADDR1;
      3'h2:    seq_pick = nvsram_host_pkg::SEQ_ADDR2;
      3'h3:    seq_pick = nvsram_host_pkg::SEQ_ADDR3;
      3'h4:    seq_pick = nvsram_host_pkg::SEQ_ADDR4;
      default: seq_pick = (op == nvsram_host_pkg::op_store) ?
                          nvsram_host_pkg::SEQ_STORE_LAST :
                          nvsram_host_pkg::SEQ_RECALL_LAST;
    endcase
  end

  // chip select is low for exactly the pulse state
  assign strobe_next = (state == st_setup && count[1:0] ==
                        nvsram_host_pkg::SETUP_LAST - 2'h1) ||
                       (state == st_pulse && count[3:0] != 4'h0);

  // sequencing; supply loss forces a fresh power-up recall wait
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state   <= st_power;
      count   <= '0;
      seq_idx <= '0;
    end else if (!supply_ok) begin
      state   <= st_power;
      count   <= '0;
      seq_idx <= '0;
    end else begin
      unique case (state)
        st_power: begin
          state <= st_wait;
          count <= nvsram_host_pkg::WAIT_W'(POWERUP_WAIT - 1);
        end
        st_idle: begin
          if (accept) begin
            state   <= st_setup;
            count   <= nvsram_host_pkg::WAIT_W'(nvsram_host_pkg::SETUP_LAST);
            seq_idx <= '0;
          end
        end
        st_setup: begin
          if (count == '0) begin
            state <= st_pulse;
            count <= nvsram_host_pkg::WAIT_W'(nvsram_host_pkg::PULSE_LAST);
          end else begin
            count <= count - 1'b1;
          end
        end
        st_pulse: begin
          if (count == '0) begin
            state <= st_hold;
          end else begin
            count <= count - 1'b1;
          end
        end
        st_hold: begin
          if (seq_active && seq_idx != nvsram_host_pkg::SEQ_LAST) begin
            seq_idx <= seq_idx + 3'h1;
            state   <= st_setup;
            count   <= nvsram_host_pkg::WAIT_W'(nvsram_host_pkg::SETUP_LAST);
          end else if (seq_active) begin
            state <= st_wait;
            count <= (op == nvsram_host_pkg::op_store) ?
                     nvsram_host_pkg::WAIT_W'(STORE_WAIT - 1) :
                     nvsram_host_pkg::WAIT_W'(
                       nvsram_host_pkg::RECALL_CYCLES - 1);
          end else begin
            state <= st_idle;
          end
        end
        st_wait: begin
          if (count == '0) begin
            state <= st_idle;
          end else begin
            count <= count - 1'b1;
          end
        end
      endcase
    end
  end

  // command capture
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      op             <= nvsram_host_pkg::op_read;
      addr           <= '0;
      data_lines_out <= nvsram_host_pkg::DATA_RESET;
    end else if (accept) begin
      op             <= cmd_op;
      addr           <= cmd_addr;
      data_lines_out <= cmd_wdata;
    end
  end

  // address changes only while chip select is high
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      address_lines <= '0;
    end else if (state == st_setup) begin
      address_lines <= seq_active ? {1'b0, seq_pick} : addr;
    end
  end

  // strobes; sequence steps are reads with output enable high
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chip_sel_n    <= 1'b1;
      out_en_n      <= 1'b1;
      write_en_n    <= 1'b1;
      data_lines_oe <= 1'b0;
    end else if (!supply_ok) begin
      chip_sel_n    <= 1'b1;
      out_en_n      <= 1'b1;
      write_en_n    <= 1'b1;
      data_lines_oe <= 1'b0;
    end else begin
      chip_sel_n    <= !strobe_next;
      out_en_n      <= !(strobe_next &&
                         op == nvsram_host_pkg::op_read);
      write_en_n    <= !(strobe_next &&
                         op == nvsram_host_pkg::op_write);
      data_lines_oe <= (strobe_next || state == st_pulse) &&
                       op == nvsram_host_pkg::op_write;
    end
  end

  // read data captured late in the pulse, past the access time
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rsp_rdata <= nvsram_host_pkg::DATA_RESET;
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      if (state == st_pulse && count == '0 &&
          op == nvsram_host_pkg::op_read) begin
        rsp_rdata <= data_sync;
        rsp_valid <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_addr_stable: assert property (
    !chip_sel_n && !$past(chip_sel_n) |-> $stable(address_lines))
    else $error("address moved while selected");
  chk_oe_in_write: assert property (
    !write_en_n |-> out_en_n)
    else $error("output enable low during write");
  chk_seq_first: assert property (
    $fell(chip_sel_n) && seq_active && seq_idx == 3'h0
    |-> address_lines == {1'b0, nvsram_host_pkg::SEQ_ADDR0})
    else $error("wrong first sequence address");
  chk_store_last: assert property (
    $fell(chip_sel_n) && op == nvsram_host_pkg::op_store &&
    seq_idx == 3'h5 |-> address_lines[13:0] == 14'h0fc0)
    else $error("wrong store final address");
  chk_recall_last: assert property (
    $fell(chip_sel_n) && op == nvsram_host_pkg::op_recall &&
    seq_idx == 3'h5 |-> address_lines[13:0] == 14'h0c63)
    else $error("wrong recall final address");
  chk_seq_no_write: assert property (
    seq_active && !chip_sel_n |-> write_en_n && !data_lines_oe)
    else $error("write during sequence");
  chk_cs_pulse: assert property (
    $fell(chip_sel_n) |-> !chip_sel_n [*8] ##1 !chip_sel_n ##1 !chip_sel_n
    ##1 chip_sel_n)
    else $error("chip select pulse length wrong");
  chk_wait_quiet: assert property (
    state == st_wait |-> chip_sel_n && write_en_n)
    else $error("pins active during device busy");
  chk_recall_wait: assert property (
    state == st_hold && op == nvsram_host_pkg::op_recall &&
    seq_idx == 3'h5 && supply_ok |=> count == 21'h0007cf)
    else $error("recall wait count wrong");
  chk_power_idle: assert property (
    !supply_ok |=> chip_sel_n && write_en_n)
    else $error("selected while supply low");

  cov_write: cover property ($fell(write_en_n));
  cov_read:  cover property (rsp_valid);
  cov_store: cover property (state == st_wait &&
                             op == nvsram_host_pkg::op_store);
  cov_recall: cover property (state == st_wait &&
                              op == nvsram_host_pkg::op_recall);

endmodule

// ==== verification/nvsram_model.sv ====
// behavioural shadowed sram answering the host pins
// assumes pins are sampled on the host clock
`timescale 1ns/100ps
module nvsram_model #(
  parameter int STORE_T  = 40,
  parameter int RECALL_T = 1000,
  parameter int PU_T     = 15
) (
  input  wire logic        clock,
  input  wire logic        supply_above_switch,
  input  wire logic [14:0] address_lines,
  input  wire logic        chip_sel_n,
  input  wire logic        out_en_n,
  input  wire logic        write_en_n,
  input  wire logic [7:0]  data_lines,
  output logic      [7:0]  dq_drv
);
  logic [7:0]  mem [0:32767];
  logic [7:0]  shadow [0:32767];
  logic [13:0] tab [0:4];
  logic [14:0] a_q;
  logic [7:0]  d_q;
  logic [7:0]  pat;
  logic        cs_q;
  logic        we_q;
  logic        pend;
  int          hold;
  int          step;
  initial begin
    for (int i = 0; i < 32768; i++) begin
      mem[i] = 8'h00;
      shadow[i] = 8'h00;
    end
    tab = '{nvsram_host_pkg::SEQ_ADDR0, nvsram_host_pkg::SEQ_ADDR1,
            nvsram_host_pkg::SEQ_ADDR2, nvsram_host_pkg::SEQ_ADDR3,
            nvsram_host_pkg::SEQ_ADDR4};
    {cs_q, we_q, pend, hold, step, pat} = {1'b1, 1'b1, 1'b1, 32'd0, 32'd0, 8'h00};
  end
  task automatic do_recall;
    for (int i = 0; i < 32768; i++) begin
      mem[i] = 8'h00;
      mem[i] = shadow[i];
    end
  endtask
  // released lines show a pattern that changes every cycle
  assign dq_drv = (!chip_sel_n && !out_en_n && write_en_n && hold == 0 &&
                   !pend) ? mem[address_lines] : pat;
  always @(posedge clock) begin
    pat <= pat + 8'h3b;
    cs_q <= chip_sel_n;
    we_q <= write_en_n;
    a_q <= address_lines;
    d_q <= data_lines;
    if (!supply_above_switch) begin
      pend <= 1'b1;
      step <= 0;
    end else if (pend) begin
      do_recall();
      hold <= PU_T;
      pend <= 1'b0;
    end else if (hold > 0) begin
      hold <= hold - 1;
    end else if (!cs_q && chip_sel_n) begin
      if (!we_q) begin
        mem[a_q] = d_q;
        step <= 0;
      end else if (step < 5) begin
        step <= (a_q[13:0] == tab[step]) ? step + 1 :
                int'(a_q[13:0] == tab[0]);
      end else begin
        step <= 0;
        if (a_q[13:0] == nvsram_host_pkg::SEQ_STORE_LAST) begin
          for (int i = 0; i < 32768; i++) shadow[i] = mem[i];
          hold <= STORE_T;
        end else if (a_q[13:0] == nvsram_host_pkg::SEQ_RECALL_LAST) begin
          do_recall();
          hold <= RECALL_T;
        end
      end
    end
  end
endmodule

// ==== verification/testbench.sv ====
// self-checking bench for the sram host sequencer
// assumes the behavioural device model on the pins
`timescale 1ns/100ps
module testbench;
  logic                 clock = 1'b0;
  logic                 rst = 1'b1;
  logic                 cmd_valid = 1'b0;
  logic                 supply_above_switch = 1'b0;
  nvsram_host_pkg::op_e cmd_op = nvsram_host_pkg::op_read;
  logic [14:0]          cmd_addr = 15'h0000;
  logic [7:0]           cmd_wdata = 8'h00;
  logic                 cmd_ready, rsp_valid, busy;
  logic                 chip_sel_n, out_en_n, write_en_n, data_lines_oe;
  logic [7:0]           rsp_rdata, data_lines_out, dq_drv, data_wire, got;
  logic [14:0]          address_lines;
  int                   bad_count = 0;
  int                   tests_run = 0;
  always #5 clock = ~clock;
  assign data_wire = data_lines_oe ? data_lines_out : dq_drv;
  nvsram_host #(.STORE_WAIT(50), .POWERUP_WAIT(20)) dut_u (
    .clock(clock), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .busy(busy), .supply_above_switch(supply_above_switch),
    .address_lines(address_lines), .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n), .write_en_n(write_en_n),
    .data_lines_in(data_wire), .data_lines_out(data_lines_out),
    .data_lines_oe(data_lines_oe));
  nvsram_model model_u (
    .clock(clock), .supply_above_switch(supply_above_switch),
    .address_lines(address_lines), .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n), .write_en_n(write_en_n),
    .data_lines(data_wire), .dq_drv(dq_drv));
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check8(input string what, input logic [7:0] exp,
                        input logic [7:0] seen);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step;
    @(posedge clock);
    #1;
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    while (cmd_ready !== 1'b1) begin
      step();
      n++;
      if (n > 5000) begin
        check8("cmd_ready", 8'h01, {7'h00, cmd_ready});
        finish_test();
      end
    end
  endtask
  task automatic issue(input nvsram_host_pkg::op_e op, input logic [14:0] a,
                       input logic [7:0] d);
    int n;
    wait_ready();
    {cmd_op, cmd_addr, cmd_wdata, cmd_valid} = {op, a, d, 1'b1};
    step();
    cmd_valid = 1'b0;
    n = 0;
    while (op == nvsram_host_pkg::op_read && rsp_valid !== 1'b1 && n < 40) begin
      step();
      n++;
    end
    got = rsp_rdata;
    if (op == nvsram_host_pkg::op_read)
      check8("read latency", 8'h0c, n[7:0]);
  endtask
  task automatic t_rw;
    issue(nvsram_host_pkg::op_write, 15'h7abc, 8'ha5);
    issue(nvsram_host_pkg::op_write, 15'h0001, 8'h3c);
    issue(nvsram_host_pkg::op_read, 15'h7abc, 8'h00);
    check8("read 7abc", 8'ha5, got);
    issue(nvsram_host_pkg::op_read, 15'h0001, 8'h00);
    check8("read 0001", 8'h3c, got);
    $display("test read write done");
  endtask
  task automatic t_store_recall;
    issue(nvsram_host_pkg::op_write, 15'h0123, 8'h55);
    issue(nvsram_host_pkg::op_store, 15'h0000, 8'h00);
    check8("busy in store", 8'h01, {7'h00, busy});
    issue(nvsram_host_pkg::op_write, 15'h0123, 8'haa);
    issue(nvsram_host_pkg::op_read, 15'h0123, 8'h00);
    check8("sram after store", 8'haa, got);
    for (int k = 0; k < 2; k++) begin
      issue(nvsram_host_pkg::op_recall, 15'h0000, 8'h00);
      issue(nvsram_host_pkg::op_read, 15'h0123, 8'h00);
      check8("recalled byte", 8'h55, got);
      issue(nvsram_host_pkg::op_write, 15'h0123, 8'h77);
    end
    $display("test store recall done");
  endtask
  task automatic t_power;
    wait_ready();
    supply_above_switch = 1'b0;
    repeat (10) step();
    check8("busy low supply", 8'h01, {7'h00, busy});
    check8("ready low supply", 8'h00, {7'h00, cmd_ready});
    supply_above_switch = 1'b1;
    issue(nvsram_host_pkg::op_read, 15'h0123, 8'h00);
    check8("power-up recall", 8'h55, got);
    $display("test power cycle done");
  endtask
  initial begin
    repeat (20) @(posedge clock);
    #1;
    rst = 1'b0;
    supply_above_switch = 1'b1;
    t_rw();
    t_store_recall();
    t_power();
    finish_test();
  end
endmodule
